/* File: hdl/mps_scrubber.sv */
// background patrol scrubber walking all ranks of a mirrored memory channel
`include "mps_consts.svh"
module mps_scrubber
    import mps_pkg::*;
#(
    parameter int RANKS  = `MPS_RANKS,
    parameter int ROWS_W = `MPS_ROWS_W
)
(
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RSTN,
    input  wire logic                  i_enable,
    input  wire logic                  i_deep_lp,
    input  wire logic [RANKS-1:0]      i_rank_present,
    input  wire logic [RANKS-1:0]      i_rank_disabled,
    input  wire logic                  i_mirror_en,
    input  wire logic                  i_cmd_ready,
    input  wire logic                  i_rd_valid,
    input  wire logic                  i_rd_sbe,
    input  wire logic                  i_rd_ue,
    input  wire logic                  i_partner_valid,
    output logic                       o_rd_req,
    output logic                       o_wr_req,
    output logic                       o_wr_from_partner,
    output logic [$clog2(RANKS)-1:0]   o_rank,
    output logic [ROWS_W-1:0]          o_row,
    output logic                       o_err_valid,
    output logic [`MPS_STAT_W-1:0]     o_err_status,
    output logic                       o_busy
);
    localparam int RW = $clog2(RANKS);

    // the location field must stay clear of the flag bits at the top
    // of the status word, and a one-rank channel has nothing to patrol
    generate
        if (RANKS < 2 || ROWS_W < 1 || RW + ROWS_W > `MPS_PCC_BIT)
        begin : g_bad_geometry
            $error("mps_scrubber: unsupported geometry");
        end
    endgenerate

    // state of the current location; rank and row double as the
    // resume point, so a pause never loses the sweep position
    mps_state_t state;
    logic       lp_s1;
    logic       lp_s2;
    logic       fix_partner;

    // rank is scrubbable when present and not disabled after training
    function automatic logic rank_ok(input logic [RANKS-1:0] pres,
                                     input logic [RANKS-1:0] dis,
                                     input logic [RW-1:0]    r);
        rank_ok = pres[r] & ~dis[r];
    endfunction

    // uncorrectable data that the mirror partner can still supply; used
    // both to pick the repair source and to downgrade the report
    function automatic logic partner_can_fix(input logic ue,
                                             input logic mir,
                                             input logic pv);
        partner_can_fix = ue & mir & pv;
    endfunction

    // next row, wrapping inside the rank
    function automatic logic [ROWS_W-1:0] row_after(
        input logic [ROWS_W-1:0] r);
        row_after = ROWS_W'(r + 1'b1);
    endfunction

    // next rank; the rank count need not be a power of two, so wrap
    // explicitly instead of relying on counter overflow
    function automatic logic [RW-1:0] rank_after(input logic [RW-1:0] r);
        if (r == RW'(RANKS - 1))
            rank_after = '0;
        else
            rank_after = RW'(r + 1'b1);
    endfunction

    // low-power level arrives from the power domain, so synchronise it;
    // a level change mid-location is only acted on back in idle
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            lp_s1 <= 1'b0;
            lp_s2 <= 1'b0;
        end
        else
        begin
            lp_s1 <= i_deep_lp;
            lp_s2 <= lp_s1;
        end
    end

    // sweep sequencer; rank map is sampled live so a spare swap is seen.
    // one location is in flight at a time: slower than pipelining reads,
    // but a pause or a map change can never strand a half-done location,
    // which is what would otherwise hang the sweep on resume
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            state             <= MPS_IDLE;
            o_rank            <= '0;
            o_row             <= '0;
            o_rd_req          <= 1'b0;
            o_wr_req          <= 1'b0;
            o_wr_from_partner <= 1'b0;
            fix_partner       <= 1'b0;
            o_busy            <= 1'b0;
        end
        else
        begin
            o_rd_req <= 1'b0;
            o_wr_req <= 1'b0;
            case (state)
                MPS_IDLE:
                begin
                    o_busy <= 1'b0;
                    // pause only between locations, position is kept
                    if (i_enable && !lp_s2)
                    begin
                        o_busy <= 1'b1;
                        // re-check the map on resume, never wait on it
                        if (rank_ok(i_rank_present, i_rank_disabled, o_rank))
                            state <= MPS_READ;
                        else
                            state <= MPS_NEXT; // skip disabled rank
                    end
                end
                MPS_READ:
                begin
                    // spare ranks are read like any other; only the
                    // present and disabled maps decide what is patrolled
                    if (i_cmd_ready)
                    begin
                        o_rd_req <= 1'b1; // every enabled location incl. spares
                        state    <= MPS_WAIT;
                    end
                end
                MPS_WAIT:
                begin
                    if (i_rd_valid)
                    begin
                        fix_partner <= partner_can_fix(i_rd_ue, i_mirror_en,
                                                       i_partner_valid);
                        if (i_rd_sbe)
                            state <= MPS_FIX; // correct single-bit
                        else if (partner_can_fix(i_rd_ue, i_mirror_en,
                                                 i_partner_valid))
                            state <= MPS_FIX; // mirror repair
                        else
                            state <= MPS_NEXT;
                    end
                end
                MPS_FIX:
                begin
                    if (i_cmd_ready)
                    begin
                        o_wr_req          <= 1'b1;
                        o_wr_from_partner <= fix_partner;
                        state             <= MPS_NEXT;
                    end
                end
                MPS_NEXT:
                begin
                    // rows wrap first, then the rank advances; skipped
                    // ranks still step row by row so timing stays even
                    o_row <= row_after(o_row);
                    if (&o_row)
                        o_rank <= rank_after(o_rank);
                    state <= MPS_IDLE;
                end
                default:
                    state <= MPS_IDLE;
            endcase
        end
    end

    // error report in machine-check status layout; the location field
    // sits at the bottom, the flags at the top, the rest stays zero.
    // the report is a one-cycle pulse, the status word holds until the
    // next report so slow logging logic can still pick it up
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RSTN)
        begin
            o_err_valid  <= 1'b0;
            o_err_status <= '0;
        end
        else
        begin
            o_err_valid <= 1'b0;
            // only enabled ranks reach WAIT, so disabled ones stay quiet
            if (state == MPS_WAIT && i_rd_valid && (i_rd_sbe || i_rd_ue))
            begin
                o_err_valid                 <= 1'b1;
                o_err_status                <= '0;
                o_err_status[`MPS_VAL_BIT]  <= 1'b1;
                o_err_status[RW+ROWS_W-1:0] <= {o_rank, o_row};
                if (i_rd_ue && !partner_can_fix(i_rd_ue, i_mirror_en,
                                                i_partner_valid))
                begin
                    // true uncorrectable: no trustworthy address
                    o_err_status[`MPS_UC_BIT]    <= 1'b1;
                    o_err_status[`MPS_PCC_BIT]   <= 1'b1;
                    o_err_status[`MPS_ADDRESS_VALID_FLAG_BIT] <= 1'b0;
                end
                else
                begin
                    // correctable, or downgraded when partner holds good data
                    o_err_status[`MPS_ADDRESS_VALID_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: hdl/mps_consts.svh */
// constants for the memory patrol scrubber
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
`define MPS_RANKS          8
`define MPS_ROWS_W         4
`define MPS_STAT_W         64
`define MPS_ADDRESS_VALID_FLAG_BIT      58
`define MPS_PCC_BIT        57
`define MPS_UC_BIT         61
`define MPS_VAL_BIT        63
`endif

/* File: hdl/mps_pkg.sv */
// types for the memory patrol scrubber
package mps_pkg;
    typedef enum logic [2:0] {
        MPS_IDLE,
        MPS_READ,
        MPS_WAIT,
        MPS_FIX,
        MPS_NEXT
    } mps_state_t;
endpackage

/* File: tb/mps_scrubber_properties.sv */
// port assertions for the patrol scrubber
module mps_props #(parameter int RANKS = 8, parameter int ROWS_W = 4)
(
    input logic                       I_CLOCK,
    input logic                       I_RSTN,
    input logic                       i_deep_lp,
    input logic [RANKS-1:0]           i_rank_disabled,
    input logic                       i_mirror_en,
    input logic                       i_rd_valid,
    input logic                       i_rd_sbe,
    input logic                       i_rd_ue,
    input logic                       i_partner_valid,
    input logic                       o_rd_req,
    input logic                       o_wr_req,
    input logic                       o_wr_from_partner,
    input logic [$clog2(RANKS)-1:0]   o_rank,
    input logic                       o_err_valid,
    input logic [63:0]                o_err_status,
    input logic                       o_busy
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);
    skip_dis_a: assert property (
        o_rd_req |-> !i_rank_disabled[o_rank]) else $error("disabled read");
    rd_pulse_a: assert property (
        o_rd_req |=> !o_rd_req) else $error("read not a pulse");
    err_follow_a: assert property (
        i_rd_valid && (i_rd_sbe || i_rd_ue) |=> o_err_valid)
        else $error("missing report");
    sbe_fix_a: assert property (
        i_rd_valid && i_rd_sbe && !i_rd_ue |-> ##[1:3] o_wr_req)
        else $error("no rewrite");
    mirror_fix_a: assert property (
        i_rd_valid && i_rd_ue && i_mirror_en && i_partner_valid
        |-> ##[1:3] o_wr_req && o_wr_from_partner) else $error("no copy");
    downgrade_a: assert property (
        o_err_valid && $past(i_rd_ue && i_mirror_en && i_partner_valid)
        |-> !o_err_status[61] && o_err_status[58]) else $error("not down");
    no_addr_a: assert property (
        o_err_valid && $past(i_rd_ue && !(i_mirror_en && i_partner_valid))
        |-> !o_err_status[58] && o_err_status[57]) else $error("addr flag");
    lp_hold_a: assert property (
        i_deep_lp [*5] ##0 !o_busy |=> !o_busy && !o_rd_req)
        else $error("ran in low power");
endmodule
bind mps_scrubber mps_props #(.RANKS(RANKS), .ROWS_W(ROWS_W)) i_props (.*);

/* File: tb/mps_dram_model.sv */
// behavioural ranks answering scrubber reads, fast or slow
module mps_dram_model
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_rd_req,
    input  wire logic i_slow,
    input  wire logic i_sbe,
    input  wire logic i_ue,
    input  wire logic i_peer,
    output logic      o_ready,
    output logic      o_valid,
    output logic      o_sbe,
    output logic      o_ue,
    output logic      o_peer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_n;
    // qualifiers toggle outside a result so stale values never match
    always_ff @(posedge i_clk)
    begin
        o_ready <= i_rstn && (i_slow ? !o_ready : 1'b1);
        wait_n  <= !i_rstn ? 2'd0 : i_rd_req ? (i_slow ? 2'd3 : 2'd1)
                 : wait_n - 2'(wait_n != 0);
        o_valid <= i_rstn && wait_n == 2'd1;
        o_sbe   <= wait_n == 2'd1 ? i_sbe : !o_sbe;
        o_ue    <= wait_n == 2'd1 ? i_ue : !o_ue;
        o_peer  <= wait_n == 2'd1 ? i_peer : !o_peer;
    end
endmodule

/* File: tb/test_memory_patrol_scrubber.sv */
// directed bench for the patrol scrubber
module test_memory_patrol_scrubber;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, en = 0, lp = 0, mir = 0, slow = 0;
    logic sbe = 0, ue = 0, pok = 0, rdy, vld, q_sbe, q_ue, q_pv;
    logic rd, wr, wfp, ev, busy, row;
    logic [3:0]  pos;
    logic [7:0]  dis = 8'h00;
    logic [2:0]  rank;
    logic [63:0] st;
    int fail_count, n_checks, nrd[8];
    always #20 clk = ~clk;
    // tally reads per rank
    always @(posedge clk) if (rd === 1'b1) nrd[rank]++;
    mps_scrubber #(.ROWS_W(1)) i_dut (.I_CLOCK(clk), .I_RSTN(rstn),
        .i_enable(en), .i_deep_lp(lp), .i_rank_present(8'hFF),
        .i_rank_disabled(dis), .i_mirror_en(mir), .i_cmd_ready(rdy),
        .i_rd_valid(vld), .i_rd_sbe(q_sbe), .i_rd_ue(q_ue),
        .i_partner_valid(q_pv), .o_rd_req(rd), .o_wr_req(wr),
        .o_wr_from_partner(wfp), .o_rank(rank), .o_row(row),
        .o_err_valid(ev), .o_err_status(st), .o_busy(busy));
    mps_dram_model i_mem (.i_clk(clk), .i_rstn(rstn), .i_rd_req(rd),
        .i_slow(slow), .i_sbe(sbe), .i_ue(ue), .i_peer(pok),
        .o_ready(rdy), .o_valid(vld), .o_sbe(q_sbe), .o_ue(q_ue),
        .o_peer(q_pv));
    task cyc(input int n); repeat (n) @(posedge clk); #1; endtask
    task chk(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // run for n cycles from a cleared tally, then park in idle
    task run(input int n); nrd = '{default: 0}; en = 1; cyc(n); en = 0;
        cyc(20); endtask
    task t_sweep; dis = 8'h08; slow = 1; sbe = 1; run(400);
        for (int r = 0; r < 8; r++) chk(nrd[r] > 0, r != 3);
        chk({st[61], st[58]}, 2'b01);
        sbe = 0; slow = 0; dis = 8'h00; endtask
    task t_ue(input logic m, input logic [1:0] e); ue = 1; mir = m; pok = m;
        run(30);
        chk({st[61], st[58]}, e);
        chk(m ? wfp : st[57], 1'b1);
        ue = 0; endtask
    task t_lp; pos = {rank, row}; lp = 1; cyc(5); run(100);
        chk(nrd.sum(), 0);
        chk({busy, rank, row}, {1'b0, pos});
        dis = 8'h81; lp = 0; en = 1; run(200);
        chk({nrd[0] > 0, nrd[7] > 0, nrd[1] > 0}, 3'b001);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin #200us; fail_count++; give_verdict; end
    initial
    begin
        cyc(20); rstn = 1; cyc(1);
        t_sweep; t_ue(1'b0, 2'b10); t_ue(1'b1, 2'b01); t_lp;
        give_verdict;
    end
endmodule
